// [hdl/ssr_pkg.sv]
// Purpose: constants for the synchronous slave serial receiver
// Assumes: 20 MHz system clock, shift clock from an external master
// Notes: register map is a plain strobe port, one byte per register
//
// What this block does
// - single receive enable is ignored; reception works as in master mode
// - reception started before sleep or idle keeps working there
// - a complete word moves from shift register to data register
// - enabled completion interrupt wakes the chip; global and peripheral enables together vector
// - nine bit select gives 9-bit words, ninth bit in status register
// - words are accepted only while continuous receive enable is set
// - completion sets the flag; interrupt request only when enabled
// - errors show in status and clear when continuous receive clears
// - low eight bits of each word are read from the data register
package ssr_pkg;
  localparam logic [2:0] SSR_ADDR_STATUS = 3'h0;
  localparam logic [2:0] SSR_ADDR_TXCTL = 3'h1;
  localparam logic [2:0] SSR_ADDR_DATA = 3'h2;
  localparam logic [2:0] SSR_ADDR_INTCTL = 3'h3;
  localparam logic [2:0] SSR_ADDR_IRQ_STAT = 3'h4;
  localparam logic [2:0] SSR_ADDR_IRQ_CLR = 3'h5;
  localparam logic [2:0] SSR_ADDR_IRQ_EN = 3'h6;
  // status register fields
  localparam int SSR_B_PORT_EN = 7;
  localparam int SSR_B_NINE = 6;
  localparam int SSR_B_SINGLE = 5;
  localparam int SSR_B_CONT = 4;
  localparam int SSR_B_OVR = 1;
  localparam int SSR_B_D9 = 0;
  // clock control fields
  localparam int SSR_B_CLK_SRC = 7;
  localparam int SSR_B_SYNC = 4;
  // interrupt control fields
  localparam int SSR_B_GLOBAL_IE = 7;
  localparam int SSR_B_PERIPH_IE = 6;
  // event bits
  localparam int SSR_EV_DONE = 0;
  localparam int SSR_EV_OVR = 1;
  localparam int SSR_NUM_EV = 2;
  localparam logic [7:0] SSR_RESET_BYTE = 8'h00;
  // last bit index of a word, counted from zero
  localparam logic [3:0] SSR_LAST8 = 4'h7;
  localparam logic [3:0] SSR_LAST9 = 4'h8;
endpackage : ssr_pkg

// [hdl/ssr_rx.sv]
// Purpose: synchronous slave receive path with strobe register port
// Assumes: shift clock well below the 20 MHz system clock
// Notes: data sampled on the shift clock's falling edge
`timescale 1ns/1ns
module ssr_rx (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [2:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // link pins
  input wire logic shift_clk_in,
  input wire logic rx_data_in,
  // low power
  input wire logic sleep_in,
  // interrupts
  output logic irq_out,
  output logic wake_out,
  output logic vector_out
);
  import ssr_pkg::*;

  logic sck_s, sck_q, dat_s;
  logic [7:0] status_r, txctl_r, intctl_r, data_r;
  logic [8:0] shift_r;
  logic [3:0] bit_cnt;
  logic d9_r, full_r;
  logic [SSR_NUM_EV-1:0] ev_stat, ev_en;

  ssr_sync u_sck (.clk_in(sys_clk_in), .reset_in(reset_in),
    .d_in(shift_clk_in), .q_out(sck_s));
  ssr_sync u_dat (.clk_in(sys_clk_in), .reset_in(reset_in),
    .d_in(rx_data_in), .q_out(dat_s));

  // slave only when sync set, port on, clock source cleared
  wire slave_mode = txctl_r[SSR_B_SYNC] & status_r[SSR_B_PORT_EN] &
    ~txctl_r[SSR_B_CLK_SRC];
  // single receive enable deliberately plays no part here
  wire rx_on = slave_mode & status_r[SSR_B_CONT];
  wire nine = status_r[SSR_B_NINE];
  // both stages reset low, so an idle-high clock gives no false fall
  wire fall = sck_q & ~sck_s;
  wire take = rx_on & fall;
  wire [3:0] last_idx = nine ? SSR_LAST9 : SSR_LAST8;
  wire word_done = take & (bit_cnt == last_idx);
  wire [8:0] next_shift = {dat_s, shift_r[8:1]};
  wire [7:0] word_byte = nine ? next_shift[7:0] : next_shift[8:1];
  wire overrun = word_done & full_r & ~(rd_in & addr_in == SSR_ADDR_DATA);
  wire rd_data = rd_in & (addr_in == SSR_ADDR_DATA);
  wire wr_stat = wr_in & (addr_in == SSR_ADDR_STATUS);
  wire cont_clr = wr_stat & ~wdata_in[SSR_B_CONT];
  wire [SSR_NUM_EV-1:0] ev_set = {overrun, word_done};
  wire [SSR_NUM_EV-1:0] ev_clr = (wr_in && addr_in == SSR_ADDR_IRQ_CLR)
    ? wdata_in[SSR_NUM_EV-1:0] : '0;
  wire irq_pend = |(ev_stat & ev_en);
  wire [7:0] status_view = {status_r[7:2], status_r[SSR_B_OVR], d9_r};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_in)
      SSR_ADDR_STATUS: rd_mux = status_view;
      SSR_ADDR_TXCTL: rd_mux = txctl_r;
      SSR_ADDR_DATA: rd_mux = data_r;
      SSR_ADDR_INTCTL: rd_mux = intctl_r;
      SSR_ADDR_IRQ_STAT: rd_mux = {6'h00, ev_stat};
      SSR_ADDR_IRQ_EN: rd_mux = {6'h00, ev_en};
      default: rd_mux = SSR_RESET_BYTE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      sck_q <= 1'b0;
      bit_cnt <= 4'h0;
      shift_r <= 9'h000;
    end else begin
      sck_q <= sck_s;
      // sleep_in is not looked at: shift clock is external
      if (!rx_on) begin
        bit_cnt <= 4'h0;
      end else if (take) begin
        shift_r <= next_shift;
        bit_cnt <= word_done ? 4'h0 : bit_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      data_r <= SSR_RESET_BYTE;
      d9_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      if (word_done) begin
        data_r <= word_byte;
        d9_r <= nine & next_shift[8];
        full_r <= 1'b1;
      end else if (rd_data) begin
        full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      status_r <= SSR_RESET_BYTE;
      txctl_r <= SSR_RESET_BYTE;
      intctl_r <= SSR_RESET_BYTE;
      ev_en <= '0;
    end else begin
      if (wr_stat) begin
        status_r[7:2] <= wdata_in[7:2];
      end
      if (wr_in && addr_in == SSR_ADDR_TXCTL) begin
        txctl_r <= wdata_in;
      end
      if (wr_in && addr_in == SSR_ADDR_INTCTL) begin
        intctl_r <= wdata_in;
      end
      if (wr_in && addr_in == SSR_ADDR_IRQ_EN) begin
        ev_en <= wdata_in[SSR_NUM_EV-1:0];
      end
      // error sticks until continuous receive is cleared; set wins
      if (overrun) begin
        status_r[SSR_B_OVR] <= 1'b1;
      end else if (cont_clr) begin
        status_r[SSR_B_OVR] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ev_stat <= '0;
      rdata_out <= SSR_RESET_BYTE;
      irq_out <= 1'b0;
      wake_out <= 1'b0;
      vector_out <= 1'b0;
    end else begin
      // set beats clear in the same cycle
      ev_stat <= (ev_stat & ~ev_clr) | ev_set;
      rdata_out <= rd_in ? rd_mux : SSR_RESET_BYTE;
      irq_out <= irq_pend;
      wake_out <= irq_pend & sleep_in;
      vector_out <= irq_pend & intctl_r[SSR_B_GLOBAL_IE] &
        intctl_r[SSR_B_PERIPH_IE];
    end
  end

  // assertions
  property p_done_moves;
    @(posedge sys_clk_in) disable iff (reset_in)
      word_done |=> data_r == $past(word_byte);
  endproperty
  a_done_moves: assert property (p_done_moves)
    else $error("word not moved");

  property p_flag;
    @(posedge sys_clk_in) disable iff (reset_in)
      word_done |=> ev_stat[SSR_EV_DONE];
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag not set");

  property p_irq;
    @(posedge sys_clk_in) disable iff (reset_in)
      irq_out |-> $past(irq_pend);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq without enable");

  property p_gate;
    @(posedge sys_clk_in) disable iff (reset_in)
      !rx_on |=> bit_cnt == 4'h0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("counting while off");

  property p_err_clr;
    @(posedge sys_clk_in) disable iff (reset_in)
      cont_clr && !overrun |=> !status_r[SSR_B_OVR];
  endproperty
  a_err_clr: assert property (p_err_clr)
    else $error("error not cleared");

  property p_d9;
    @(posedge sys_clk_in) disable iff (reset_in)
      word_done && !nine |=> !d9_r;
  endproperty
  a_d9: assert property (p_d9)
    else $error("ninth bit in 8-bit mode");

  property p_wake;
    @(posedge sys_clk_in) disable iff (reset_in)
      irq_pend && sleep_in |=> wake_out;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake");

  property p_cnt;
    @(posedge sys_clk_in) disable iff (reset_in)
      bit_cnt <= SSR_LAST9;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("bit count out of range");

  property p_rd_idle;
    @(posedge sys_clk_in) disable iff (reset_in)
      !rd_in |=> rdata_out == SSR_RESET_BYTE;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data without strobe");

  property p_rd_data;
    @(posedge sys_clk_in) disable iff (reset_in)
      rd_data |=> rdata_out == $past(data_r);
  endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("data register read wrong");

  property p_ovr_set;
    @(posedge sys_clk_in) disable iff (reset_in)
      overrun |=> status_r[SSR_B_OVR];
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun not reported");

  property p_ovr_ev;
    @(posedge sys_clk_in) disable iff (reset_in)
      overrun |=> ev_stat[SSR_EV_OVR];
  endproperty
  a_ovr_ev: assert property (p_ovr_ev)
    else $error("overrun event not set");

  property p_d9_pair;
    @(posedge sys_clk_in) disable iff (reset_in)
      word_done && nine |=> d9_r == $past(dat_s);
  endproperty
  a_d9_pair: assert property (p_d9_pair)
    else $error("ninth bit not paired");

  property p_data_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      !word_done |=> $stable(data_r);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data changed without a word");

  property p_vec;
    @(posedge sys_clk_in) disable iff (reset_in)
      irq_pend && intctl_r[SSR_B_GLOBAL_IE] && intctl_r[SSR_B_PERIPH_IE]
        |=> vector_out;
  endproperty
  a_vec: assert property (p_vec)
    else $error("no vector request");

  property p_irq_on;
    @(posedge sys_clk_in) disable iff (reset_in)
      irq_pend |=> irq_out;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("enabled event without irq");

  property p_wake_awake;
    @(posedge sys_clk_in) disable iff (reset_in)
      !sleep_in |=> !wake_out;
  endproperty
  a_wake_awake: assert property (p_wake_awake)
    else $error("wake while awake");

  property p_cnt_step;
    @(posedge sys_clk_in) disable iff (reset_in)
      take && !word_done |=> bit_cnt == $past(bit_cnt) + 4'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step)
    else $error("bit count did not step");

  property p_done_rst;
    @(posedge sys_clk_in) disable iff (reset_in)
      word_done |=> bit_cnt == 4'h0;
  endproperty
  a_done_rst: assert property (p_done_rst)
    else $error("bit count not restarted");

  property p_flag_hold;
    @(posedge sys_clk_in) disable iff (reset_in)
      ev_stat[SSR_EV_DONE] && !ev_clr[SSR_EV_DONE] |=> ev_stat[SSR_EV_DONE];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost without clear");

  c_word: cover property (@(posedge sys_clk_in) word_done);
  c_nine: cover property (@(posedge sys_clk_in) word_done && nine);
  c_ovr: cover property (@(posedge sys_clk_in) overrun);
  c_wake: cover property (@(posedge sys_clk_in) wake_out);
endmodule : ssr_rx

// [hdl/ssr_sync.sv]
// Purpose: two flop synchroniser for a pin level
// Assumes: input from outside the clock domain
// Notes: first stage read by second stage only
`timescale 1ns/1ns
module ssr_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // level
  input wire logic d_in,
  output logic q_out
);
  logic meta;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta <= 1'b0;
      q_out <= 1'b0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule : ssr_sync

// [verif/ssr_master_model.sv]
// Purpose: external master that drives the shift clock and data pins
// Assumes: 400 ns shift clock, receiver samples on the falling edge
// Notes: clock idles high between frames; released data is inverted
`timescale 1ns/1ns
module ssr_master_model (
  // link pins
  output logic sclk_out,
  output logic sdata_out
);
  initial begin
    sclk_out = 1'b1;
    sdata_out = 1'b0;
  end
  // clock runs only inside a frame
  task automatic send(input logic [8:0] w, input int n);
    #13;
    for (int i = 0; i < n; i++) begin
      sdata_out = w[i]; // lsb first
      #200 sclk_out = 1'b0;
      #200 sclk_out = 1'b1;
    end
    // data held only 100 ns after the frame, then inverted so the old level does not linger
    #100 sdata_out = ~sdata_out;
  endtask : send
endmodule : ssr_master_model

// [verif/sync_slave_serial_receiver_tb.sv]
// Purpose: self-checking bench for the slave serial receiver
// Assumes: 20 MHz clock, master model on the link pins
// Notes: reads queue their expected byte; a watcher compares
`timescale 1ns/1ns
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module sync_slave_serial_receiver_tb;
  import ssr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata, e;
  logic sclk, sdat, irq, wake, vec;
  logic [8:0] w;
  logic [7:0] expq[$];
  int err_total = 0;
  int checks = 0;
  always #25 clk = ~clk;
  ssr_rx dut (.sys_clk_in(clk), .reset_in(rst), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .shift_clk_in(sclk), .rx_data_in(sdat), .sleep_in(sleep),
    .irq_out(irq), .wake_out(wake), .vector_out(vec));
  ssr_master_model m (.sclk_out(sclk), .sdata_out(sdat));
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      e = expq.pop_front();
      `CHK(rdata, e)
    end
  end
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    expq.push_back(x);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    `CHK(irq, 1'b1)
  endtask : wait_irq
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #400000;
    err_total++;
    test_done();
  end
  initial begin
    w = 9'($urandom(32'ha06920ad));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(3'h7, 8'h00); // unmapped reads as zero
    wr_reg(SSR_ADDR_TXCTL, 8'h10); // sync slave
    wr_reg(SSR_ADDR_STATUS, 8'hb0); // single bit set too
    wr_reg(SSR_ADDR_IRQ_EN, 8'h03);
    wr_reg(SSR_ADDR_INTCTL, 8'hc0);
    w = 9'($urandom);
    m.send(w, 8);
    wait_irq();
    repeat (2) @(posedge clk);
    `CHK(vec, 1'b1)
    rd_reg(SSR_ADDR_IRQ_STAT, 8'h01);
    rd_reg(SSR_ADDR_DATA, w[7:0]);
    wr_reg(SSR_ADDR_IRQ_CLR, 8'h01);
    rd_reg(SSR_ADDR_IRQ_STAT, 8'h00);
    $display("test plain word done");
    wr_reg(SSR_ADDR_STATUS, 8'h90);
    w = 9'($urandom);
    m.send(w, 8);
    m.send(w, 8);
    repeat (10) @(posedge clk);
    rd_reg(SSR_ADDR_STATUS, 8'h92);
    rd_reg(SSR_ADDR_IRQ_STAT, 8'h03);
    wr_reg(SSR_ADDR_STATUS, 8'h80);
    rd_reg(SSR_ADDR_STATUS, 8'h80);
    rd_reg(SSR_ADDR_DATA, w[7:0]);
    wr_reg(SSR_ADDR_IRQ_CLR, 8'h03);
    $display("test overrun done");
    m.send(9'($urandom), 8);
    repeat (10) @(posedge clk);
    rd_reg(SSR_ADDR_IRQ_STAT, 8'h00);
    wr_reg(SSR_ADDR_TXCTL, 8'h90);
    wr_reg(SSR_ADDR_STATUS, 8'h90);
    m.send(9'($urandom), 8);
    repeat (10) @(posedge clk);
    rd_reg(SSR_ADDR_IRQ_STAT, 8'h00);
    wr_reg(SSR_ADDR_TXCTL, 8'h10);
    wr_reg(SSR_ADDR_STATUS, 8'h90);
    wr_reg(SSR_ADDR_IRQ_EN, 8'h00);
    m.send(w, 8);
    repeat (10) @(posedge clk);
    `CHK(irq, 1'b0)
    wr_reg(SSR_ADDR_IRQ_EN, 8'h03);
    wait_irq();
    rd_reg(SSR_ADDR_DATA, w[7:0]);
    wr_reg(SSR_ADDR_IRQ_CLR, 8'h01);
    $display("test gating done");
    sleep <= 1'b1;
    wr_reg(SSR_ADDR_STATUS, 8'hd0);
    w = 9'($urandom);
    m.send(w, 9);
    wait_irq();
    repeat (2) @(posedge clk);
    `CHK(wake, 1'b1)
    rd_reg(SSR_ADDR_STATUS, {7'h68, w[8]});
    rd_reg(SSR_ADDR_DATA, w[7:0]);
    repeat (3) @(posedge clk);
    $display("test sleep nine bit done");
    test_done();
  end
endmodule : sync_slave_serial_receiver_tb
